// ==== prsg_pkg.sv ====
// Package for the ramp and sweep generator: widths, codes, states, config carriers
// Assumes a single comparison-rate clock and synchronous configuration inputs
package prsg_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int DEV_W = 16;
    localparam int SHIFT_W = 4;
    localparam int STEP_W = 20;
    localparam int DIV_W = 12;
    localparam int DLY_W = 12;
    localparam int TMR_W = 24;
    localparam int ACC_W = 56;
    localparam int SET_N = 2;

    // ------------------------------------------------------------
    // Reset values and ramp type codes
    // ------------------------------------------------------------
    localparam logic [ACC_W-1:0] ACC_RST = 56'h00000000000000;
    localparam logic [STEP_W-1:0] STEP_RST = 20'h00000;
    localparam logic [TMR_W-1:0] TMR_RST = 24'h000000;
    localparam logic [DLY_W-1:0] DLY_UNIT_ONE = 12'h001;
    localparam logic [1:0] RAMP_SAW = 2'h0;
    localparam logic [1:0] RAMP_TRI = 2'h1;
    localparam logic [1:0] RAMP_SSAW = 2'h2;
    localparam logic [1:0] RAMP_SBURST = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DELAY = 3'h1,
        ST_RAMP = 3'h2,
        ST_RETURN = 3'h3,
        ST_HOLD = 3'h4
    } prsg_state_t;

    typedef struct packed {
        logic [DEV_W-1:0] step_deviation_word;
        logic [SHIFT_W-1:0] deviation_shift;
    } prsg_dev_t;

    typedef struct packed {
        logic [1:0] ramp_type;
        logic ramp_start;
        logic counter_reset;
        logic two_rate_en;
        logic fsk_en;
        logic parabolic_en;
        logic delay_start_en;
        logic delay_scale;
        logic delay_between_en;
        logic fast_lock_en;
        logic [DLY_W-1:0] delay_word;
        logic [DIV_W-1:0] step_timer_divider_a;
        logic [DIV_W-1:0] step_timer_divider_b;
    } prsg_cfg_t;

endpackage : prsg_pkg

// ==== prsg_timer.sv ====
// Interval timer: pulses once every period cycles while enabled
// Assumes the enable drops for a cycle whenever the count must restart
`timescale 1ns/1ps
module prsg_timer
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    input wire logic [prsg_pkg::TMR_W-1:0] period_i,
    output logic tick_o
);

    logic [prsg_pkg::TMR_W-1:0] cnt_q;
    logic [prsg_pkg::TMR_W-1:0] cnt_d;
    logic [prsg_pkg::TMR_W-1:0] last;

    // ------------------------------------------------------------
    // Count and expiry
    // ------------------------------------------------------------
    always_comb
    begin
        last = (period_i == prsg_pkg::TMR_RST) ? prsg_pkg::TMR_RST : period_i - 24'h000001;
        tick_o = en_i && (cnt_q >= last);
        if (!en_i || tick_o)
        begin
            cnt_d = prsg_pkg::TMR_RST;
        end
        else
        begin
            cnt_d = cnt_q + 24'h000001;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_q <= prsg_pkg::TMR_RST;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

endmodule : prsg_timer

// ==== prsg_core.sv ====
// Ramp and sweep generator stepping the fractional divide offset
// Assumes config and write strobes come from host logic on the same clock
`timescale 1ns/1ps
module prsg_core
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire prsg_pkg::prsg_cfg_t cfg_i,
    input wire logic dev_wr_i,
    input wire logic dev_sel_i,
    input wire prsg_pkg::prsg_dev_t dev_i,
    input wire logic step_wr_i,
    input wire logic step_sel_i,
    input wire logic [prsg_pkg::STEP_W-1:0] step_cnt_i,
    output logic [prsg_pkg::ACC_W-1:0] frac_offset_o,
    output logic ramp_busy_o,
    output logic fast_lock_o,
    output logic rate_sel_o
);

    localparam int AW = prsg_pkg::ACC_W;

    function automatic logic signed [AW-1:0] dev_inc(input prsg_pkg::prsg_dev_t d);
        logic signed [AW-1:0] ext;
        ext = {{(AW-prsg_pkg::DEV_W){d.step_deviation_word[prsg_pkg::DEV_W-1]}},
               d.step_deviation_word};
        return ext <<< d.deviation_shift;
    endfunction : dev_inc

    // ------------------------------------------------------------
    // Stored deviation sets and step counts
    // ------------------------------------------------------------
    prsg_pkg::prsg_dev_t dev_set_q [prsg_pkg::SET_N];
    prsg_pkg::prsg_dev_t dev_set_d [prsg_pkg::SET_N];
    logic [prsg_pkg::STEP_W-1:0] steps_q [prsg_pkg::SET_N];
    logic [prsg_pkg::STEP_W-1:0] steps_d [prsg_pkg::SET_N];

    generate
        for (genvar s = 0; s < prsg_pkg::SET_N; s++)
        begin : g_set
            always_comb
            begin
                dev_set_d[s] = (dev_wr_i && (int'(dev_sel_i) == s)) ? dev_i : dev_set_q[s];
                steps_d[s] = (step_wr_i && (int'(step_sel_i) == s)) ? step_cnt_i : steps_q[s];
            end
            always_ff @(posedge clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    dev_set_q[s] <= '0;
                    steps_q[s] <= prsg_pkg::STEP_RST;
                end
                else
                begin
                    dev_set_q[s] <= dev_set_d[s];
                    steps_q[s] <= steps_d[s];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    prsg_pkg::prsg_state_t state_q;
    prsg_pkg::prsg_state_t state_d;
    logic step_tick;
    logic dly_tick;
    logic [prsg_pkg::TMR_W-1:0] step_period;
    logic [prsg_pkg::TMR_W-1:0] dly_period;
    logic [prsg_pkg::DLY_W-1:0] dly_unit;

    assign dly_unit = cfg_i.delay_scale ? cfg_i.step_timer_divider_a : prsg_pkg::DLY_UNIT_ONE;
    assign dly_period = cfg_i.delay_word * dly_unit;
    assign step_period = cfg_i.step_timer_divider_a * cfg_i.step_timer_divider_b;

    prsg_timer u_step_timer
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .en_i((state_q == prsg_pkg::ST_RAMP) || (state_q == prsg_pkg::ST_RETURN)),
        .period_i(step_period),
        .tick_o(step_tick)
    );

    prsg_timer u_dly_timer
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .en_i(state_q == prsg_pkg::ST_DELAY),
        .period_i(dly_period),
        .tick_o(dly_tick)
    );

    // ------------------------------------------------------------
    // Sweep sequencer
    // ------------------------------------------------------------
    logic signed [AW-1:0] acc_q, acc_d, incr_q, incr_d, out_q, out_d, lin;
    logic [prsg_pkg::STEP_W-1:0] cnt_q, cnt_d, act_steps_q, act_steps_d;
    logic [prsg_pkg::DLY_W-1:0] fl_cnt_q, fl_cnt_d;
    prsg_pkg::prsg_dev_t act_dev_q, act_dev_d;
    logic dir_q, dir_d, rate_q, rate_d, fsk_q, fsk_d, fl_q, fl_d;
    logic launch, finish, use_dly;

    always_comb
    begin
        state_d = state_q;
        acc_d = acc_q;
        incr_d = incr_q;
        cnt_d = cnt_q;
        dir_d = dir_q;
        rate_d = rate_q;
        fsk_d = fsk_q;
        fl_d = fl_q;
        fl_cnt_d = fl_cnt_q;
        act_dev_d = act_dev_q;
        act_steps_d = act_steps_q;
        launch = 1'b0;
        finish = 1'b0;
        use_dly = 1'b0;
        lin = dev_inc(act_dev_q);
        if (!cfg_i.ramp_start)
        begin
            state_d = prsg_pkg::ST_IDLE;
            fl_d = 1'b0;
        end
        else
        begin
            unique case (state_q)
                prsg_pkg::ST_IDLE:
                begin
                    acc_d = prsg_pkg::ACC_RST;
                    incr_d = prsg_pkg::ACC_RST;
                    fsk_d = 1'b0;
                    rate_d = 1'b0;
                    launch = 1'b1;
                    use_dly = cfg_i.delay_start_en;
                end
                prsg_pkg::ST_DELAY:
                begin
                    if (dly_tick)
                    begin
                        state_d = prsg_pkg::ST_RAMP;
                    end
                end
                prsg_pkg::ST_RAMP:
                begin
                    if (step_tick)
                    begin
                        fsk_d = cfg_i.fsk_en ? !fsk_q : 1'b0;
                        if (cfg_i.parabolic_en)
                        begin
                            if (dir_q)
                            begin
                                acc_d = acc_q - incr_q;
                                incr_d = incr_q - lin;
                            end
                            else
                            begin
                                incr_d = incr_q + lin;
                                acc_d = acc_q + incr_d;
                            end
                        end
                        else
                        begin
                            acc_d = dir_q ? acc_q - lin : acc_q + lin;
                        end
                        cnt_d = cnt_q + 20'h00001;
                        if (cnt_d >= act_steps_q)
                        begin
                            cnt_d = prsg_pkg::STEP_RST;
                            if (cfg_i.ramp_type == prsg_pkg::RAMP_SBURST)
                            begin
                                state_d = prsg_pkg::ST_HOLD;
                            end
                            else if (cfg_i.ramp_type == prsg_pkg::RAMP_TRI)
                            begin
                                dir_d = !dir_q;
                                finish = dir_q;
                            end
                            else
                            begin
                                state_d = prsg_pkg::ST_RETURN;
                            end
                        end
                    end
                end
                prsg_pkg::ST_RETURN:
                begin
                    if (step_tick)
                    begin
                        acc_d = prsg_pkg::ACC_RST;
                        incr_d = prsg_pkg::ACC_RST;
                        fsk_d = 1'b0;
                        if (cfg_i.ramp_type == prsg_pkg::RAMP_SSAW)
                        begin
                            state_d = prsg_pkg::ST_HOLD;
                        end
                        else
                        begin
                            finish = 1'b1;
                        end
                    end
                end
                prsg_pkg::ST_HOLD:
                begin
                    state_d = prsg_pkg::ST_HOLD;
                end
                default:
                begin
                    state_d = prsg_pkg::ST_IDLE;
                end
            endcase
            if (finish)
            begin
                rate_d = cfg_i.two_rate_en ? !rate_q : rate_q;
                launch = 1'b1;
                use_dly = cfg_i.delay_between_en;
                fl_d = cfg_i.delay_between_en && cfg_i.fast_lock_en;
                fl_cnt_d = '0;
            end
            else if (fl_q)
            begin
                fl_cnt_d = fl_cnt_q + 12'h001;
                fl_d = (fl_cnt_d < dly_unit) && (state_q == prsg_pkg::ST_DELAY);
            end
            if (launch)
            begin
                act_dev_d = dev_set_q[(cfg_i.fsk_en || !rate_d) ? 0 : 1];
                act_steps_d = steps_q[(cfg_i.fsk_en || !rate_d) ? 0 : 1];
                cnt_d = prsg_pkg::STEP_RST;
                dir_d = 1'b0;
                state_d = use_dly ? prsg_pkg::ST_DELAY : prsg_pkg::ST_RAMP;
            end
        end
        if (cfg_i.counter_reset)
        begin
            acc_d = prsg_pkg::ACC_RST;
            incr_d = prsg_pkg::ACC_RST;
            cnt_d = prsg_pkg::STEP_RST;
            dir_d = 1'b0;
            fsk_d = 1'b0;
        end
        out_d = fsk_d ? acc_d + dev_inc(dev_set_q[1]) : acc_d;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= prsg_pkg::ST_IDLE;
            acc_q <= prsg_pkg::ACC_RST;
            incr_q <= prsg_pkg::ACC_RST;
            out_q <= prsg_pkg::ACC_RST;
            cnt_q <= prsg_pkg::STEP_RST;
            act_steps_q <= prsg_pkg::STEP_RST;
            act_dev_q <= '0;
            fl_cnt_q <= '0;
            dir_q <= 1'b0;
            rate_q <= 1'b0;
            fsk_q <= 1'b0;
            fl_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            acc_q <= acc_d;
            incr_q <= incr_d;
            out_q <= out_d;
            cnt_q <= cnt_d;
            act_steps_q <= act_steps_d;
            act_dev_q <= act_dev_d;
            fl_cnt_q <= fl_cnt_d;
            dir_q <= dir_d;
            rate_q <= rate_d;
            fsk_q <= fsk_d;
            fl_q <= fl_d;
        end
    end

    assign frac_offset_o = out_q;
    assign ramp_busy_o = (state_q == prsg_pkg::ST_DELAY) || (state_q == prsg_pkg::ST_RAMP)
                         || (state_q == prsg_pkg::ST_RETURN);
    assign fast_lock_o = fl_q;
    assign rate_sel_o = rate_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_enter_delay;
        (state_q != prsg_pkg::ST_DELAY) ##1 (state_q == prsg_pkg::ST_DELAY);
    endsequence

    chk_stop_holds: assert property ((!cfg_i.ramp_start && !cfg_i.counter_reset) |=> $stable(acc_q))
        else $error("Offset moved while ramp stopped");
    chk_dev_store: assert property ((dev_wr_i && dev_sel_i) |=> dev_set_q[1] == $past(dev_i))
        else $error("Second deviation set not loaded");
    chk_step_store: assert property ((step_wr_i && !step_sel_i) |=> steps_q[0] == $past(step_cnt_i))
        else $error("First step count not loaded");
    chk_linear_step: assert property ((state_q == prsg_pkg::ST_RAMP && step_tick && !dir_q
        && cfg_i.ramp_start && !cfg_i.parabolic_en && !cfg_i.counter_reset)
        |=> acc_q == $past(acc_q) + $past(lin))
        else $error("Linear step increment wrong");
    chk_parab_step: assert property ((state_q == prsg_pkg::ST_RAMP && step_tick && !dir_q
        && cfg_i.ramp_start && cfg_i.parabolic_en && !cfg_i.counter_reset)
        |=> incr_q == $past(incr_q) + $past(lin) && acc_q == $past(acc_q) + incr_q)
        else $error("Parabolic increment wrong");
    chk_saw_return: assert property ((state_q == prsg_pkg::ST_RETURN && step_tick
        && cfg_i.ramp_start) |=> acc_q == prsg_pkg::ACC_RST)
        else $error("Sawtooth did not return");
    chk_tri_turn: assert property ((state_q == prsg_pkg::ST_RAMP && step_tick && !dir_q
        && cfg_i.ramp_start && !cfg_i.counter_reset && cfg_i.ramp_type == prsg_pkg::RAMP_TRI
        && cnt_q + 20'h00001 >= act_steps_q) |=> dir_q)
        else $error("Triangle did not turn down");
    chk_delay_unscaled: assert property ((s_enter_delay ##0 (!cfg_i.delay_scale
        && cfg_i.delay_word == 12'h003)) |-> (state_q == prsg_pkg::ST_DELAY)[*3]
        ##1 (state_q != prsg_pkg::ST_DELAY))
        else $error("Unscaled delay length wrong");
    chk_delay_scaled: assert property ((s_enter_delay ##0 (cfg_i.delay_scale
        && cfg_i.delay_word == 12'h002 && cfg_i.step_timer_divider_a == 12'h002))
        |-> (state_q == prsg_pkg::ST_DELAY)[*4] ##1 (state_q != prsg_pkg::ST_DELAY))
        else $error("Scaled delay length wrong");
    chk_delay_start: assert property ((state_q == prsg_pkg::ST_IDLE && cfg_i.ramp_start
        && cfg_i.delay_start_en) |=> state_q == prsg_pkg::ST_DELAY)
        else $error("Delayed start skipped");
    chk_step_period: assert property ((step_tick && step_period == 24'h000006)
        |=> !step_tick[*5])
        else $error("Step interval too short");
    chk_fast_lock: assert property (fast_lock_o |-> state_q == prsg_pkg::ST_DELAY
        && cfg_i.fast_lock_en)
        else $error("Fast-lock outside inter-ramp delay");
    chk_rate_toggle: assert property ((rate_q != $past(rate_q)
        && $past(state_q) != prsg_pkg::ST_IDLE) |-> $past(cfg_i.two_rate_en))
        else $error("Rate select toggled without two-rate mode");
    chk_active_kept: assert property ((state_q == prsg_pkg::ST_RAMP && state_d == prsg_pkg::ST_RAMP
        && !finish) |=> $stable(act_dev_q) && $stable(act_steps_q))
        else $error("Running ramp settings disturbed");
    chk_fsk_toggle: assert property ((state_q == prsg_pkg::ST_RAMP && step_tick && cfg_i.fsk_en
        && cfg_i.ramp_start && !cfg_i.counter_reset) |=> fsk_q != $past(fsk_q))
        else $error("FSK did not alternate");

endmodule : prsg_core

// ==== prsg_host_model.sv ====
// Host model: configuration levels and deviation and step writes
// Assumes callers enter its tasks at a falling clock edge
`timescale 1ns/1ps
module prsg_host_model
(
    input wire logic clk_i,
    output prsg_pkg::prsg_cfg_t cfg_o,
    output logic dev_wr_o,
    output logic dev_sel_o,
    output prsg_pkg::prsg_dev_t dev_o,
    output logic step_wr_o,
    output logic step_sel_o,
    output logic [prsg_pkg::STEP_W-1:0] step_cnt_o
);
    // ------------------------------------------------------------
    // Idle levels and write pulses
    // ------------------------------------------------------------
    initial
    begin
        cfg_o = '0;
        {dev_wr_o, dev_sel_o, step_wr_o, step_sel_o} = 4'h0;
        dev_o = '0;
        step_cnt_o = '0;
    end

    task automatic wr_dev(input logic sel, input logic [15:0] w, input logic [3:0] sh);
        dev_sel_o = sel;
        dev_o = {w, sh};
        dev_wr_o = 1'b1;
        @(negedge clk_i);
        dev_wr_o = 1'b0;
        @(negedge clk_i);
    endtask : wr_dev

    task automatic wr_step(input logic sel, input int n);
        step_sel_o = sel;
        step_cnt_o = 20'(n);
        step_wr_o = 1'b1;
        @(negedge clk_i);
        step_wr_o = 1'b0;
        @(negedge clk_i);
    endtask : wr_step

    // ------------------------------------------------------------
    // Programming sequence and activation
    // ------------------------------------------------------------
    task automatic load_ramp(input logic [1:0] typ, input int n0, input int n1,
                             input logic [15:0] w0, input logic [3:0] s0,
                             input logic [15:0] w1, input logic [3:0] s1);
        wr_step(1'b0, n0);
        wr_step(1'b1, n1);
        wr_dev(1'b0, w0, s0);
        wr_dev(1'b1, w1, s1);
        cfg_o.ramp_type = typ;
    endtask : load_ramp

    task automatic arm(input logic para);
        cfg_o.parabolic_en = para;
        cfg_o.counter_reset = 1'b1;
        @(negedge clk_i);
        cfg_o.counter_reset = 1'b0;
        @(negedge clk_i);
        cfg_o.ramp_start = 1'b1;
    endtask : arm
endmodule : prsg_host_model

// ==== prsg_core_tb_top.sv ====
// Bench for the ramp generator: host model, reference queue, checks
// Assumes the package and the host model are compiled before it
`timescale 1ns/1ps
module prsg_core_tb_top;
    // ------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    prsg_pkg::prsg_cfg_t cfg;
    prsg_pkg::prsg_dev_t dev;
    logic dev_wr, dev_sel, step_wr, step_sel, fast_lock, rate_sel, busy;
    logic [prsg_pkg::STEP_W-1:0] step_cnt;
    logic [prsg_pkg::ACC_W-1:0] frac;
    int error_cnt = 0;
    int n_tests = 0;
    int ns[2];
    logic [15:0] ws[2];
    logic [3:0] ss[2];
    longint is[2];
    longint q[$];
    logic [15:0] rnd = 16'h0011;
    int wd;

    always #25 clk_i = ~clk_i;

    prsg_host_model u_host (.clk_i(clk_i), .cfg_o(cfg), .dev_wr_o(dev_wr), .dev_sel_o(dev_sel),
        .dev_o(dev), .step_wr_o(step_wr), .step_sel_o(step_sel), .step_cnt_o(step_cnt));

    prsg_core DUT (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg), .dev_wr_i(dev_wr),
        .dev_sel_i(dev_sel), .dev_i(dev), .step_wr_i(step_wr), .step_sel_i(step_sel),
        .step_cnt_i(step_cnt), .frac_offset_o(frac), .ramp_busy_o(busy),
        .fast_lock_o(fast_lock), .rate_sel_o(rate_sel));

    // ------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [prsg_pkg::ACC_W-1:0] seen,
                       input logic [prsg_pkg::ACC_W-1:0] want);
        n_tests++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", nm, want, seen);
        end
    endtask : chk

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic fresh(input int a, input int b);
        u_host.cfg_o = '0;
        u_host.cfg_o.step_timer_divider_a = 12'(a);
        u_host.cfg_o.step_timer_divider_b = 12'(b);
        for (int s = 0; s < 2; s++)
        begin
            rnd = lfsr(rnd);
            ns[s] = 2 + int'(rnd[1:0]);
            ws[s] = {6'h00, rnd[9:0]} + 16'h0001;
            ss[s] = rnd[13:10];
            is[s] = longint'(ws[s]) << ss[s];
        end
    endtask : fresh

    task automatic gen(input int typ, input bit two, input bit para, input int len);
        int s;
        longint acc;
        s = 0;
        acc = 0;
        q = {};
        while (q.size() < len)
        begin
            for (int i = 1; i <= ns[s]; i++)
            begin
                acc += para ? i * is[s] : is[s];
                q.push_back(acc);
            end
            if (typ == 1)
                for (int i = ns[s]; i >= 1; i--)
                begin
                    acc -= para ? i * is[s] : is[s];
                    q.push_back(acc);
                end
            else if (typ != 3)
            begin
                acc = 0;
                q.push_back(acc);
            end
            while (typ >= 2 && q.size() < len)
                q.push_back(acc);
            if (two)
                s ^= 1;
        end
    endtask : gen

    task automatic run(input string nm, input int ab, input int dly, input longint alt);
        longint e;
        int hit;
        hit = 0;
        e = 0;
        @(posedge clk_i);
        repeat (dly + 1) @(posedge clk_i);
        foreach (q[k])
        begin
            repeat (ab) @(posedge clk_i);
            @(negedge clk_i);
            e = q[k];
            if (alt != 0 && frac === e[prsg_pkg::ACC_W-1:0] + alt[prsg_pkg::ACC_W-1:0])
            begin
                e += alt;
                hit++;
            end
            chk("frac_offset", frac, e[prsg_pkg::ACC_W-1:0]);
        end
        if (alt != 0)
            chk("fsk_hits", 56'(hit > 0), 56'h1);
        u_host.cfg_o.ramp_start = 1'b0;
        repeat (2 * ab) @(negedge clk_i);
        chk("held_offset", frac, e[prsg_pkg::ACC_W-1:0]);
        chk("busy_idle", 56'(busy), 56'h0);
        $display("Test %s done", nm);
    endtask : run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (10) @(negedge clk_i);
        chk("idle_offset", frac, 56'h0);
        chk("idle_busy", 56'({busy, fast_lock, rate_sel}), 56'h0);
        for (int t = 0; t < 4; t++)
        begin
            fresh(3 + t, 1 + (t & 1));
            u_host.load_ramp(2'(t), ns[0], ns[1], ws[0], ss[0], ws[1], ss[1]);
            u_host.arm(1'b0);
            gen(t, 1'b0, 1'b0, 12);
            run("ramp_type", (3 + t) * (1 + (t & 1)), 0, 0);
        end
        fresh(3, 2);
        u_host.cfg_o.two_rate_en = 1'b1;
        u_host.load_ramp(2'h0, ns[0], ns[1], ws[0], ss[0], ws[1] + 16'h0010, ss[1]);
        fork
            begin
                repeat (3) @(negedge clk_i);
                u_host.wr_dev(1'b1, ws[1], ss[1]);
            end
        join_none
        u_host.arm(1'b0);
        gen(0, 1'b1, 1'b0, 16);
        run("two_rate", 6, 0, 0);
        for (int t = 1; t < 4; t += 2)
        begin
            fresh(3, 1);
            u_host.load_ramp(2'(t), ns[0], ns[1], ws[0], ss[0], ws[1], ss[1]);
            u_host.arm(1'b1);
            gen(t, 1'b0, 1'b1, 10);
            run("parabolic", 3, 0, 0);
        end
        for (int sc = 0; sc < 2; sc++)
        begin
            fresh(3 - sc, 1);
            u_host.cfg_o.delay_start_en = 1'b1;
            u_host.cfg_o.delay_scale = 1'(sc);
            u_host.cfg_o.delay_word = sc ? 12'h002 : 12'h003;
            u_host.load_ramp(2'h3, ns[0], ns[1], ws[0], ss[0], ws[1], ss[1]);
            u_host.arm(1'b0);
            gen(3, 1'b0, 1'b0, 4);
            run("delayed_start", 3 - sc, 3 + sc, 0);
        end
        fresh(3, 1);
        u_host.cfg_o.fsk_en = 1'b1;
        u_host.load_ramp(2'h0, ns[0], ns[1], ws[0], ss[0], ws[1], ss[1]);
        u_host.arm(1'b0);
        gen(0, 1'b0, 1'b0, 8);
        run("fsk_on_ramp", 3, 0, is[1]);
        fresh(3, 1);
        u_host.cfg_o.delay_between_en = 1'b1;
        u_host.cfg_o.fast_lock_en = 1'b1;
        u_host.cfg_o.delay_word = 12'h004;
        u_host.load_ramp(2'h0, ns[0], ns[1], ws[0], ss[0], ws[1], ss[1]);
        u_host.arm(1'b0);
        wd = 0;
        while (fast_lock !== 1'b1 && wd < 200)
        begin
            @(negedge clk_i);
            wd++;
        end
        chk("fast_lock_on", 56'(fast_lock), 56'h1);
        chk("between_offset", frac, 56'h0);
        @(negedge clk_i);
        chk("fast_lock_unit", 56'(fast_lock), 56'h0);
        repeat (2) @(negedge clk_i);
        chk("delay_hold", frac, 56'h0);
        repeat (9) @(negedge clk_i);
        chk("ramp_resumed", 56'(frac != 56'h0), 56'h1);
        u_host.cfg_o.ramp_start = 1'b0;
        rstn_i = 1'b0;
        @(negedge clk_i);
        chk("reset_offset", frac, 56'h0);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk("reset_state", 56'({busy, fast_lock, rate_sel}), 56'h0);
        $display("Test delay_between done");
        complete_run();
    end

    initial
    begin
        #(50 * 40000);
        error_cnt++;
        complete_run();
    end
endmodule : prsg_core_tb_top
